// File: logic/cycle_tick_divider.sv
// divides the oscillator clock down to the instruction cycle clock tick
`default_nettype none

module cycle_tick_divider #(
   parameter int DIV = pmt_pkg::CYCLE_DIV,
   parameter int W = pmt_pkg::DIV_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic restart,
   output logic tick,
   output logic first_half
);

   // ------------------------------------------------------------
   // phase counter
   // ------------------------------------------------------------
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   // wrap at the end of each cycle, restart aligns a fresh cycle
   always_comb
   begin
      if (restart || count == W'(DIV - 1))
         next_count = '0;
      else
         next_count = count + W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         count <= '0;
      else if (ce)
         count <= next_count;
   end

   // tick marks the last oscillator clock of a cycle
   assign tick = (count == W'(DIV - 1));
   assign first_half = (count < W'(DIV / 2));

endmodule

`default_nettype wire

// File: logic/pulse_modulator_timer.sv
// modulator and pwm timer driving one output pin, wishbone register access
// What this block does
// R1: 8-bit down counter and 8-bit reload register at index 0cf supplying start value.
// R2: mode from high select, low select, run: normal, square, pwm, two modulators.
// R3: modulator uses oscillator clock when low select is 1, else cycle clock.
// R4: cycle clock is oscillator divided by ten; clocks pwm modes and slow modulator.
// R5: setting run copies reload into counter and starts; no counter rewrite needed.
// R6: reload value n-1 yields n pulses or counts, at most 256.
// R7: modulator passes selected clock pulses to output pin until counter underflows.
// R8: modulator underflow clears run, stops counter, holds pin low until restart.
// R9: clearing run by software stops the counter at once.
// R10: square mode toggles pin and reloads on each underflow until run cleared.
// R11: pwm mode: wide timer underflow sets run, starts counter, drives pin high.
// R12: pwm mode: counter underflow clears run, pin low until next timer underflow.
// R13: software puts the wide timer in reload-with-toggle mode before pwm use.
// R14: software configures the output pin direction before any modulator mode.
// R15: reset clears run and both mode selects, leaving normal port mode.
// R16: wide timer underflow is one pulse per underflow, starting one period.
//
// Implementation choice: the Wishbone slave port.
`default_nettype none

module pulse_modulator_timer #(
   parameter int CNT_W = pmt_pkg::CNT_W,
   parameter int DIV = pmt_pkg::CYCLE_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pmt_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic wide_timer_underflow,
   output logic modulator_output_pin,
   output logic pin_function_active
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   pmt_pkg::ctrl_t ctrl;
   pmt_pkg::ctrl_t next_ctrl;
   pmt_pkg::ctrl_t written_ctrl;
   logic [CNT_W-1:0] reload;
   logic [CNT_W-1:0] next_reload;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic out_level;
   logic next_out_level;
   logic osc_phase;
   logic next_osc_phase;
   logic ack;
   logic next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic restart_div;
   logic pin_active;
   logic next_pin_active;

   pmt_pkg::mode_t mode;
   pmt_pkg::mode_t written_mode;
   logic cycle_tick;
   logic cycle_first_half;
   logic req;
   logic wr_ctrl;
   logic wr_reload;
   logic at_zero;

   // ------------------------------------------------------------
   // cycle clock
   // ------------------------------------------------------------
   // the divider restarts on every start so the first pulse is whole
   cycle_tick_divider #(
      .DIV(DIV),
      .W(pmt_pkg::DIV_W)
   ) u_div (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .restart(restart_div),
      .tick(cycle_tick),
      .first_half(cycle_first_half)
   ); // R4

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one request per handshake: ack blocks a second take
   assign req = wb_cyc_i && wb_stb_i && !ack;
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pmt_pkg::CTRL_ADDR);
   assign wr_reload = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pmt_pkg::RELOAD_ADDR);
   assign mode = pmt_pkg::decode_mode(ctrl); // R2

   // value software writes into the control bits
   always_comb
   begin
      written_ctrl.run = wb_dat_i[pmt_pkg::RUN_BIT];
      written_ctrl.mode_low = wb_dat_i[pmt_pkg::MODE_LOW_BIT];
      written_ctrl.mode_high = wb_dat_i[pmt_pkg::MODE_HIGH_BIT];
      written_mode = pmt_pkg::decode_mode(written_ctrl);
   end

   assign at_zero = (count == '0);

   // ------------------------------------------------------------
   // next state: counting engine, software access, timer start
   // ------------------------------------------------------------
   always_comb
   begin
      next_ctrl = ctrl;
      next_reload = reload;
      next_count = count;
      next_out_level = out_level;
      next_osc_phase = osc_phase;
      restart_div = 1'b0;

      // counting engine on the current mode
      if (!ctrl.run)
      begin
         // stopped: pin rests low
         next_out_level = 1'b0; // R8 R12
         next_osc_phase = 1'b0;
      end
      else
      begin
         case (mode)
            pmt_pkg::mode_mod_cycle:
            begin
               next_out_level = cycle_first_half; // R7 R3
               if (cycle_tick)
               begin
                  if (at_zero)
                  begin
                     next_ctrl.run = 1'b0; // R8
                     next_out_level = 1'b0; // R8
                  end
                  else
                     next_count = count - CNT_W'(1); // R6
               end
            end
            pmt_pkg::mode_mod_osc:
            begin
               // each oscillator pulse is one high and one low clock
               next_osc_phase = !osc_phase;
               next_out_level = !osc_phase; // R7 R3
               if (osc_phase)
               begin
                  if (at_zero)
                  begin
                     next_ctrl.run = 1'b0; // R8
                     next_out_level = 1'b0; // R8
                  end
                  else
                     next_count = count - CNT_W'(1); // R6
               end
            end
            pmt_pkg::mode_square:
            begin
               if (cycle_tick)
               begin
                  if (at_zero)
                  begin
                     next_out_level = !out_level; // R10
                     next_count = reload; // R10
                  end
                  else
                     next_count = count - CNT_W'(1);
               end
            end
            pmt_pkg::mode_pwm:
            begin
               if (cycle_tick)
               begin
                  if (at_zero)
                  begin
                     next_ctrl.run = 1'b0; // R12
                     next_out_level = 1'b0; // R12
                  end
                  else
                     next_count = count - CNT_W'(1);
               end
            end
            default:
               next_out_level = 1'b0;
         endcase
      end

      // software writes: reload value and control bits
      if (wr_reload)
         next_reload = wb_dat_i[CNT_W-1:0]; // R1
      if (wr_ctrl)
      begin
         next_ctrl = written_ctrl;
         if (written_ctrl.run)
         begin
            // every set of run reloads and starts from a fresh cycle
            next_count = reload; // R5
            next_osc_phase = 1'b0;
            next_out_level = (written_mode == pmt_pkg::mode_pwm);
            restart_div = 1'b1;
         end
         else
         begin
            next_out_level = 1'b0; // R9
            next_osc_phase = 1'b0;
         end
      end

      // timer underflow start wins over a clear in the same cycle
      if (wide_timer_underflow && !next_ctrl.mode_high && next_ctrl.mode_low) // R16
      begin
         next_ctrl.run = 1'b1; // R11
         next_count = wr_reload ? wb_dat_i[CNT_W-1:0] : reload; // R11
         next_out_level = 1'b1; // R11
         restart_div = 1'b1;
      end

      // pin function follows the control bits as they stand after this edge
      next_pin_active = (pmt_pkg::decode_mode(next_ctrl) != pmt_pkg::mode_normal); // R2
   end

   // ------------------------------------------------------------
   // next bus answer
   // ------------------------------------------------------------
   // ack one cycle after the take; unmapped reads return zero
   always_comb
   begin
      next_ack = req;
      next_rdata = rdata;
      if (req && !wb_we_i)
      begin
         next_rdata = '0;
         if (wb_adr_i == pmt_pkg::CTRL_ADDR)
         begin
            next_rdata[pmt_pkg::RUN_BIT] = ctrl.run;
            next_rdata[pmt_pkg::MODE_LOW_BIT] = ctrl.mode_low;
            next_rdata[pmt_pkg::MODE_HIGH_BIT] = ctrl.mode_high;
         end
         else if (wb_adr_i == pmt_pkg::RELOAD_ADDR)
            next_rdata[CNT_W-1:0] = reload;
         else if (wb_adr_i == pmt_pkg::STATUS_ADDR)
         begin
            next_rdata[CNT_W-1:0] = count;
            next_rdata[pmt_pkg::STATUS_OUT_BIT] = out_level;
            next_rdata[pmt_pkg::STATUS_RUN_BIT] = ctrl.run;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // reset leaves the pin in normal port mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl <= pmt_pkg::CTRL_RESET; // R15
         reload <= pmt_pkg::RELOAD_RESET;
         count <= '0;
         out_level <= 1'b0;
         osc_phase <= 1'b0;
         pin_active <= 1'b0; // R15
      end
      else if (ce)
      begin
         ctrl <= next_ctrl;
         reload <= next_reload;
         count <= next_count;
         out_level <= next_out_level;
         osc_phase <= next_osc_phase;
         pin_active <= next_pin_active;
      end
   end

   // bus answer registers, frozen with the rest while ce is low
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ack <= 1'b0;
         rdata <= '0;
      end
      else if (ce)
      begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
   assign modulator_output_pin = out_level;
   assign pin_function_active = pin_active; // R2

endmodule

`default_nettype wire

// File: shared/pmt_pkg.sv
// constants, types and helpers shared by the pulse modulator timer
`default_nettype none

package pmt_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [7:0] CTRL_INDEX = 8'hcc;   // second_control_reg
   localparam logic [7:0] RELOAD_INDEX = 8'hcf; // pulse_reload_reg
   localparam logic [7:0] STATUS_INDEX = 8'hd0; // counter and pin state
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'b00, CTRL_INDEX, 2'b00};
   localparam logic [ADDR_W-1:0] RELOAD_ADDR = {2'b00, RELOAD_INDEX, 2'b00};
   localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'b00, STATUS_INDEX, 2'b00};

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int RUN_BIT = 5;
   localparam int MODE_LOW_BIT = 6;
   localparam int MODE_HIGH_BIT = 7;
   localparam int STATUS_OUT_BIT = 8;
   localparam int STATUS_RUN_BIT = 9;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam int CNT_W = 8;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int OSC_HZ = 100_000_000;
   localparam int CYCLE_DIV = 10;                 // oscillator clocks per cycle clock
   localparam int DIV_W = 4;
   localparam int CYCLE_NS = CYCLE_DIV * 1_000_000_000 / OSC_HZ;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      mode_normal,
      mode_square,
      mode_pwm,
      mode_mod_cycle,
      mode_mod_osc
   } mode_t;

   typedef struct packed {
      logic mode_high;
      logic mode_low;
      logic run;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{mode_high: 1'b0, mode_low: 1'b0, run: 1'b0};

   // mode decode from high select, low select, run
   function automatic mode_t decode_mode(input ctrl_t c);
      mode_t m;
      m = mode_normal;
      if (c.mode_high)
         m = c.mode_low ? mode_mod_osc : mode_mod_cycle;
      else if (c.mode_low)
         m = mode_pwm;
      else if (c.run)
         m = mode_square;
      return m;
   endfunction

endpackage

`default_nettype wire

// File: test/pin_load_model.sv
// emitter load on the modulator output pin, counting pulses
`default_nettype none
module pin_load_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic [15:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last;
   // pin is a driven output into the emitter; count rising edges
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rises <= 16'h0;
         last <= 1'b0;
      end
      else
      begin
         if (pin && !last)
            rises <= rises + 16'h1;
         last <= pin;
      end
   end
endmodule
`default_nettype wire

// File: test/pulse_modulator_timer_monitor.sv
// port checker for the pulse modulator timer
`default_nettype none
module pulse_modulator_timer_monitor #(
   parameter int CNT_W = 8,
   parameter int DIV = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pmt_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wide_timer_underflow,
   input wire logic modulator_output_pin,
   input wire logic pin_function_active
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic wr;
   logic [1:0] mode;
   logic run;
   logic [7:0] rel;
   logic p_pin;
   logic seen;
   logic [11:0] lvl;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // shadow of written controls, level length
   // ----------------------------------------
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   assign wr = take && wb_we_i && wb_sel_i[0];
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode <= 2'b00;
         run <= 1'b0;
         rel <= 8'h00;
         p_pin <= 1'b0;
         seen <= 1'b0;
         lvl <= 12'h000;
      end
      else
      begin
         if (wr && wb_adr_i == pmt_pkg::CTRL_ADDR)
         begin
            mode <= wb_dat_i[7:6];
            run <= wb_dat_i[5];
         end
         if (wr && wb_adr_i == pmt_pkg::RELOAD_ADDR)
            rel <= wb_dat_i[7:0];
         p_pin <= modulator_output_pin;
         lvl <= (modulator_output_pin != p_pin) ? 12'h001 : lvl + 12'h001;
         seen <= (mode == 2'b00 && run) && (seen || modulator_output_pin != p_pin);
      end
   end
   ack_one_cycle_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   ack_timely_a:
      assert property (take |=> wb_ack_o) else $error("ack missing");
   ack_cause_a:
      assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
   read_upper_a:
      assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:10] == 22'h0)
         else $error("upper read bits set");
   mode_active_a:
      assert property (pin_function_active == (mode != 2'b00 || run))
         else $error("pin function wrong");
   idle_low_a:
      assert property ((mode == 2'b00 && !run) [*2] |-> !modulator_output_pin)
         else $error("pin high in port mode");
   pwm_rise_a:
      assert property (mode == 2'b01 && wide_timer_underflow |=> modulator_output_pin)
         else $error("pwm start missed");
   pwm_width_a:
      assert property (mode == 2'b01 && $fell(modulator_output_pin) |-> lvl == (rel + 1) * DIV)
         else $error("pwm width wrong");
   square_period_a:
      assert property (seen && run && mode == 2'b00 && modulator_output_pin != p_pin |->
         lvl == (rel + 1) * DIV)
         else $error("square period wrong");
   osc_pulse_a:
      assert property (mode == 2'b11 && modulator_output_pin |=> !modulator_output_pin)
         else $error("fast pulse too wide");
   cyc_pulse_a:
      assert property (mode == 2'b10 && $fell(modulator_output_pin) |-> lvl == DIV / 2)
         else $error("slow pulse width wrong");
endmodule
bind pulse_modulator_timer pulse_modulator_timer_monitor #(.CNT_W(CNT_W), .DIV(DIV)) mon_u (
   .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wide_timer_underflow(wide_timer_underflow),
   .modulator_output_pin(modulator_output_pin), .pin_function_active(pin_function_active));
`default_nettype wire

// File: test/pulse_modulator_timer_tb.sv
// self-checking bench for the pulse modulator timer
`default_nettype none
module pulse_modulator_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CT = pmt_pkg::CTRL_ADDR;
   localparam logic [11:0] RL = pmt_pkg::RELOAD_ADDR;
   localparam logic [11:0] ST = pmt_pkg::STATUS_ADDR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0;
   logic uf = 1'b0;
   logic [31:0] rdat;
   logic ack;
   logic pin;
   logic act;
   logic [15:0] rises;
   logic [15:0] r0;
   logic [31:0] q;
   int fail_count = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   pulse_modulator_timer dut_u (.clk(clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wide_timer_underflow(uf), .modulator_output_pin(pin),
      .pin_function_active(act));
   pin_load_model load_u (.clk(clk), .rst(rst), .pin(pin), .rises(rises));
   // ----------------------------------------
   // bus, compare and closing tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      check("ack", {31'h0, ack}, 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_stop();
      int n;
      n = 0;
      do
      begin
         bus(1'b0, ST, 8'h00);
         n++;
      end
      while (q[9] !== 1'b0 && n < 400);
      check("run", {31'h0, q[9]}, 32'h0);
      check("pin level", {31'h0, q[8]}, 32'h0);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic burst(input logic [7:0] c, input logic [7:0] rel, input bit load);
      if (load)
         bus(1'b1, RL, rel);
      r0 = rises;
      bus(1'b1, CT, c);
      wait_stop();
      check("pulses", {16'h0, rises - r0}, {24'h0, rel} + 32'h1);
      repeat (20) @(posedge clk);
      check("pin", {31'h0, pin}, 32'h0);
   endtask
   task automatic t_reset();
      bus(1'b0, CT, 8'h00);
      check("ctrl", q, 32'h0);
      bus(1'b0, RL, 8'h00);
      check("reload", q, 32'h0);
      check("active", {31'h0, act}, 32'h0);
      bus(1'b0, 12'h000, 8'h00);
      check("unmapped", q, 32'h0);
      bus(1'b1, RL, 8'ha5);
      bus(1'b0, RL, 8'h00);
      check("reload", q, 32'ha5);
      $display("reset test done");
   endtask
   task automatic t_modulate();
      burst(8'he0, 8'h03, 1'b1);
      burst(8'he0, 8'h03, 1'b0);
      burst(8'he0, 8'h00, 1'b1);
      burst(8'he0, 8'hff, 1'b1);
      burst(8'ha0, 8'h02, 1'b1);
      $display("modulator test done");
   endtask
   task automatic t_stop();
      bus(1'b1, RL, 8'hff);
      bus(1'b1, CT, 8'he0);
      repeat (50) @(posedge clk);
      bus(1'b1, CT, 8'hc0);
      repeat (2) @(posedge clk);
      r0 = rises;
      repeat (30) @(posedge clk);
      check("stopped", {16'h0, rises}, {16'h0, r0});
      check("pin", {31'h0, pin}, 32'h0);
      bus(1'b0, ST, 8'h00);
      check("run", {31'h0, q[9]}, 32'h0);
      check("halted early", {31'h0, q[7:0] != 8'h00}, 32'h1);
      $display("stop test done");
   endtask
   task automatic t_square();
      bus(1'b1, RL, 8'h01);
      r0 = rises;
      bus(1'b1, CT, 8'h20);
      repeat (130) @(posedge clk);
      check("active", {31'h0, act}, 32'h1);
      check("toggling", {31'h0, (rises - r0) > 16'h2}, 32'h1);
      bus(1'b1, CT, 8'h00);
      repeat (2) @(posedge clk);
      check("pin", {31'h0, pin}, 32'h0);
      $display("square test done");
   endtask
   task automatic t_pwm();
      bus(1'b1, CT, 8'h40);
      r0 = rises;
      repeat (2)
      begin
         repeat (5) @(posedge clk);
         uf <= 1'b1;
         @(posedge clk);
         uf <= 1'b0;
         #1;
         check("pwm high", {31'h0, pin}, 32'h1);
         repeat (25) @(posedge clk);
         check("pwm low", {31'h0, pin}, 32'h0);
      end
      check("pwm count", {16'h0, rises - r0}, 32'h2);
      bus(1'b1, CT, 8'h00);
      $display("pwm test done");
   endtask
   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_modulate();
      t_stop();
      t_square();
      t_pwm();
      give_verdict();
   end
endmodule
`default_nettype wire
